// ---- core/gauge_consts.svh ----
// command codes, subcommands, field positions and fixed values of the gauge decoder
`ifndef GAUGE_CONSTS_SVH
`define GAUGE_CONSTS_SVH

// standard command codes
`define CODE_CTL_LO       8'h00
`define CODE_CTL_HI       8'h01
`define CODE_CHARGE       8'h02
`define CODE_MAX_ERR      8'h03
`define CODE_REMAIN       8'h04
`define CODE_FULL_CAP     8'h06
`define CODE_POTENTIAL    8'h08
`define CODE_MEAN_CUR     8'h0A
`define CODE_THERMAL      8'h0C
`define CODE_STATUS_A     8'h0E
`define CODE_INST_CUR     8'h10
`define CODE_STATUS_B     8'h12

// block read windows
`define CODE_MFR_BASE     8'h40
`define MFR_LEN           16
`define CODE_CHEM_BASE    8'h50
`define CHEM_LEN          4

// control subcommands
`define SUB_STATUS        16'h0000
`define SUB_DEV_TYPE      16'h0001
`define SUB_FW_REV        16'h0002
`define SUB_HW_REV        16'h0003
`define SUB_RESET_DATA    16'h0005
`define SUB_PREV          16'h0007
`define SUB_CHEM_CODE     16'h0008
`define SUB_BOARD_OFS     16'h0009
`define SUB_CC_MEASURE    16'h000A
`define SUB_CC_COMMIT     16'h000B
`define SUB_CFG_REV       16'h000C
`define SUB_DEEP_SLEEP    16'h0010
`define SUB_SEAL          16'h0020
`define SUB_GAUGE_EN      16'h0021
`define SUB_CAL_TOGGLE    16'h002D
`define SUB_FULL_RESET    16'h0041
`define SUB_EXIT_CAL      16'h0080
`define SUB_ENTER_CAL     16'h0081
`define SUB_OFFSET_CAL    16'h0082

// previous-subcommand record keeps only codes below this
`define PREV_LIMIT        16'h0020

// control status word bit positions
`define CS_SEALED         13
`define CS_CALEN          12
`define CS_CCA            11
`define CS_BCA            10
`define CS_CSV            9
`define CS_DEEP_SLEEP     5
`define CS_SLEEP          4
`define CS_LDMD           3
`define CS_RUP_DIS        2
`define CS_VOK            1
`define CS_QEN            0

// reset values
`define RST_SEALED        1'b0
`define RST_WORD          16'h0000
`define RST_BYTE          8'h00

`endif

// ---- core/gauge_pkg.sv ----
// types shared by the gauge command decoder
package gauge_pkg;

  // source of the word returned at the control codes
  typedef enum logic [3:0] {
    RSP_STATUS,
    RSP_TYPE,
    RSP_FW,
    RSP_HW,
    RSP_RESETS,
    RSP_PREV,
    RSP_CHEM,
    RSP_CFG,
    RSP_OFFSET
  } resp_sel_t;

endpackage

// ---- core/text_rom.sv ----
// constant text string addressed one byte at a time
`timescale 1ns/1ps
`default_nettype none

module text_rom #(
  parameter int          LEN  = 4,
  parameter logic [8*LEN-1:0] TEXT = '0
) (
  input  wire logic [7:0] idx,
  output logic      [7:0] data
);

  // first character sits in the top byte; beyond the end reads zero
  always_comb begin
    data = 8'h00;
    for (int i = 0; i < LEN; i++) begin
      if (idx == 8'(i)) begin
        data = TEXT[8*(LEN-1-i) +: 8];
      end
    end
  end

endmodule // text_rom

`default_nettype wire

// ---- core/gauge_command_decoder.sv ----
// host command interpreter of the battery gauge
//
// Behaviour
// - standard commands carry a two-byte word the host reads or writes
// - fixed codes: 0x02, 0x03 single bytes, word pairs 0x04/0x05 to 0x12/0x13
// - standard commands answered only in normal operating power mode
// - two block reads return manufacturer name and chemistry strings
// - control word read-write in both states, measurements read-only always
// - write of two-byte subcommand to 0x00/0x01 runs the chosen control function
// - 0x0020 seals the device, honoured only while unsealed
// - 0x0000 reports the key feature status word, allowed while sealed
// - 0x0001 to 0x0003 return type, firmware and hardware revision
// - 0x0007 returns previous control subcommand, allowed while sealed
// - 0x0008 returns chemistry identifier of the active configuration
// - 0x0009 starts and stores a board offset measurement, allowed sealed
// - 0x000A starts counter offset measurement without committing it
// - 0x000B commits the measured counter offset
// - 0x000C returns configuration data revision in both states
// - 0x0010 sets the deep-sleep flag of the control status word
// - 0x0021 enables the gauging algorithm, only while unsealed
// - unsealed: 0x002D toggles calibration enable, 0x0081 enters, 0x0080 leaves
// - 0x0041 requests full device reset, only while unsealed
// - 0x0082 reports counter offset in calibration mode, only unsealed
// - sealed state shown on bit 5 of control status high byte
`timescale 1ns/1ps
`default_nettype none
`include "gauge_consts.svh"

module gauge_command_decoder #(
  parameter logic [15:0]        DEVICE_TYPE = 16'h0A5A,  // arbitrary value
  parameter logic [8*16-1:0]    MFR_TEXT    = "GAUGE MAKER     ",
  parameter logic [8*4-1:0]     CHEM_TEXT   = "LION"
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  input  wire logic              normal_mode,
  // byte access from the link layer
  input  wire logic              acc_valid,
  input  wire logic              acc_write,
  input  wire logic [7:0]        acc_addr,
  input  wire logic [7:0]        acc_wdata,
  output var  logic              rd_valid_ff,
  output var  logic [7:0]        rd_data_ff,
  // measurement values
  input  wire logic [7:0]        charge_percent,
  input  wire logic [7:0]        max_error_percent,
  input  wire logic [15:0]       remaining_capacity,
  input  wire logic [15:0]       full_charge_capacity,
  input  wire logic [15:0]       pack_potential_mv,
  input  wire logic [15:0]       mean_current,
  input  wire logic [15:0]       thermal_reading,
  input  wire logic [15:0]       gauge_status_word_a,
  input  wire logic [15:0]       instant_current,
  input  wire logic [15:0]       gauge_status_word_b,
  // identification and calibration values
  input  wire logic [15:0]       fw_rev,
  input  wire logic [15:0]       hw_rev,
  input  wire logic [15:0]       chem_code,
  input  wire logic [15:0]       cfg_rev,
  input  wire logic [15:0]       reset_count,
  input  wire logic [15:0]       counter_offset_measure,
  // core status
  input  wire logic              checksum_valid,
  input  wire logic              board_cal_busy,
  input  wire logic              cc_cal_busy,
  input  wire logic              sleep_mode,
  input  wire logic              const_power_mode,
  input  wire logic              ra_update_off,
  input  wire logic              vok_clear,
  // control outputs
  output var  logic              sealed_ff,
  output var  logic              cal_allow_ff,
  output var  logic              cal_mode_ff,
  output var  logic              gauging_algorithm_enable_ff,
  output var  logic              vok_ff,
  output var  logic              deep_sleep_flag_ff,
  output var  logic              board_cal_start_ff,
  output var  logic              counter_offset_measure_ff,
  output var  logic              counter_offset_commit_ff,
  output var  logic              full_reset_ff,
  output var  logic              gauging_start_ff
);

  import gauge_pkg::*;

  // ---------------------------------------------------------------
  // access decode
  // ---------------------------------------------------------------
  logic        take;
  logic        wr_ctl_lo;
  logic        wr_ctl_hi;
  logic [15:0] sub;
  logic [7:0]  ctl_lo_ff;

  // accesses only in normal power mode
  assign take      = ce && acc_valid && normal_mode;
  // only the control codes accept writes
  assign wr_ctl_lo = take && acc_write && (acc_addr == `CODE_CTL_LO);
  assign wr_ctl_hi = take && acc_write && (acc_addr == `CODE_CTL_HI);
  // low byte then high byte form the subcommand
  assign sub       = {acc_wdata, ctl_lo_ff};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_lo_ff <= `RST_BYTE;
    end else if (wr_ctl_lo) begin
      ctl_lo_ff <= acc_wdata;
    end
  end

  // ---------------------------------------------------------------
  // subcommand permission
  // ---------------------------------------------------------------
  logic known;
  logic sealed_free;
  logic run;

  always_comb begin
    known       = 1'b1;
    sealed_free = 1'b0;
    unique case (sub)
      `SUB_STATUS, `SUB_DEV_TYPE, `SUB_FW_REV, `SUB_HW_REV,
      `SUB_RESET_DATA, `SUB_PREV, `SUB_CHEM_CODE, `SUB_BOARD_OFS,
      `SUB_CC_MEASURE, `SUB_CC_COMMIT, `SUB_CFG_REV,
      `SUB_DEEP_SLEEP: sealed_free = 1'b1;
      `SUB_SEAL, `SUB_GAUGE_EN, `SUB_CAL_TOGGLE, `SUB_FULL_RESET,
      `SUB_EXIT_CAL, `SUB_ENTER_CAL: sealed_free = 1'b0;
      `SUB_OFFSET_CAL: known = cal_mode_ff;
      default: known = 1'b0;
    endcase
  end

  // forbidden or unknown codes change nothing
  assign run = wr_ctl_hi && known && (sealed_free || !sealed_ff);

  // ---------------------------------------------------------------
  // access state
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sealed_ff <= `RST_SEALED;
    end else if (run && sub == `SUB_SEAL) begin
      sealed_ff <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // answer word selection
  // ---------------------------------------------------------------
  resp_sel_t   resp_sel_ff;
  logic [15:0] prev_ff;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resp_sel_ff <= RSP_STATUS;
    end else if (run) begin
      unique case (sub)
        `SUB_STATUS:     resp_sel_ff <= RSP_STATUS;
        `SUB_DEV_TYPE:   resp_sel_ff <= RSP_TYPE;
        `SUB_FW_REV:     resp_sel_ff <= RSP_FW;
        `SUB_HW_REV:     resp_sel_ff <= RSP_HW;
        `SUB_RESET_DATA: resp_sel_ff <= RSP_RESETS;
        `SUB_PREV:       resp_sel_ff <= RSP_PREV;
        `SUB_CHEM_CODE:  resp_sel_ff <= RSP_CHEM;
        `SUB_CFG_REV:    resp_sel_ff <= RSP_CFG;
        `SUB_OFFSET_CAL: resp_sel_ff <= RSP_OFFSET;
        default:         resp_sel_ff <= resp_sel_ff;
      endcase
    end
  end

  // record of the last accepted subcommand, small codes only; the query itself is not kept
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= `RST_WORD;
    end else if (run && sub < `PREV_LIMIT && sub != `SUB_PREV) begin
      prev_ff <= sub;
    end
  end

  // ---------------------------------------------------------------
  // calibration and gauging state
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_allow_ff <= 1'b0;
    end else if (run && sub == `SUB_CAL_TOGGLE) begin
      cal_allow_ff <= !cal_allow_ff;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_mode_ff <= 1'b0;
    end else if (run && sub == `SUB_ENTER_CAL && cal_allow_ff) begin
      cal_mode_ff <= 1'b1;
    end else if (run && sub == `SUB_EXIT_CAL) begin
      cal_mode_ff <= 1'b0;
    end
  end

  // once enabled the algorithm stays enabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gauging_algorithm_enable_ff <= 1'b0;
    end else if (run && sub == `SUB_GAUGE_EN) begin
      gauging_algorithm_enable_ff <= 1'b1;
    end
  end

  // set by the enable wins over the core's clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vok_ff <= 1'b0;
    end else if (ce) begin
      if (run && sub == `SUB_GAUGE_EN) begin
        vok_ff <= 1'b1;
      end else if (vok_clear) begin
        vok_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      deep_sleep_flag_ff <= 1'b0;
    end else if (run && sub == `SUB_DEEP_SLEEP) begin
      deep_sleep_flag_ff <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // one-cycle action requests to the core
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      board_cal_start_ff        <= 1'b0;
      counter_offset_measure_ff <= 1'b0;
      counter_offset_commit_ff  <= 1'b0;
      full_reset_ff             <= 1'b0;
      gauging_start_ff          <= 1'b0;
    end else if (ce) begin
      board_cal_start_ff        <= run && sub == `SUB_BOARD_OFS;
      counter_offset_measure_ff <= run && sub == `SUB_CC_MEASURE;
      counter_offset_commit_ff  <= run && sub == `SUB_CC_COMMIT;
      full_reset_ff             <= run && sub == `SUB_FULL_RESET;
      gauging_start_ff          <= run && sub == `SUB_GAUGE_EN;
    end
  end

  // ---------------------------------------------------------------
  // control word contents
  // ---------------------------------------------------------------
  logic [15:0] status_word;
  logic [15:0] ctl_word;

  always_comb begin
    status_word                 = 16'h0000;
    status_word[`CS_SEALED]     = sealed_ff;
    status_word[`CS_CALEN]      = cal_mode_ff;
    status_word[`CS_CCA]        = cc_cal_busy;
    status_word[`CS_BCA]        = board_cal_busy;
    status_word[`CS_CSV]        = checksum_valid;
    status_word[`CS_DEEP_SLEEP] = deep_sleep_flag_ff;
    status_word[`CS_SLEEP]      = sleep_mode;
    status_word[`CS_LDMD]       = const_power_mode;
    status_word[`CS_RUP_DIS]    = ra_update_off;
    status_word[`CS_VOK]        = vok_ff;
    status_word[`CS_QEN]        = gauging_algorithm_enable_ff;
  end

  always_comb begin
    unique case (resp_sel_ff)
      RSP_STATUS: ctl_word = status_word;
      RSP_TYPE:   ctl_word = DEVICE_TYPE;
      RSP_FW:     ctl_word = fw_rev;
      RSP_HW:     ctl_word = hw_rev;
      RSP_RESETS: ctl_word = reset_count;
      RSP_PREV:   ctl_word = prev_ff;
      RSP_CHEM:   ctl_word = chem_code;
      RSP_CFG:    ctl_word = cfg_rev;
      RSP_OFFSET: ctl_word = counter_offset_measure;
      default:    ctl_word = 16'h0000;
    endcase
  end

  // ---------------------------------------------------------------
  // block read strings
  // ---------------------------------------------------------------
  logic [7:0] mfr_idx;
  logic [7:0] chem_idx;
  logic [7:0] mfr_byte;
  logic [7:0] chem_byte;
  logic       in_mfr;
  logic       in_chem;

  assign mfr_idx  = acc_addr - `CODE_MFR_BASE;
  assign chem_idx = acc_addr - `CODE_CHEM_BASE;
  assign in_mfr   = (acc_addr >= `CODE_MFR_BASE) && (mfr_idx < 8'(`MFR_LEN));
  assign in_chem  = (acc_addr >= `CODE_CHEM_BASE) && (chem_idx < 8'(`CHEM_LEN));

  text_rom #(
    .LEN  (`MFR_LEN),
    .TEXT (MFR_TEXT)
  ) u_mfr_rom (
    .idx  (mfr_idx),
    .data (mfr_byte)
  );

  text_rom #(
    .LEN  (`CHEM_LEN),
    .TEXT (CHEM_TEXT)
  ) u_chem_rom (
    .idx  (chem_idx),
    .data (chem_byte)
  );

  // ---------------------------------------------------------------
  // read data path
  // ---------------------------------------------------------------
  logic [15:0] word;
  logic [7:0]  rd_byte;

  // word of the code pair, odd code returns the high byte
  always_comb begin
    unique case ({acc_addr[7:1], 1'b0})
      `CODE_CTL_LO:    word = ctl_word;
      `CODE_REMAIN:    word = remaining_capacity;
      `CODE_FULL_CAP:  word = full_charge_capacity;
      `CODE_POTENTIAL: word = pack_potential_mv;
      `CODE_MEAN_CUR:  word = mean_current;
      `CODE_THERMAL:   word = thermal_reading;
      `CODE_STATUS_A:  word = gauge_status_word_a;
      `CODE_INST_CUR:  word = instant_current;
      `CODE_STATUS_B:  word = gauge_status_word_b;
      default:         word = 16'h0000;
    endcase
  end

  always_comb begin
    if (acc_addr == `CODE_CHARGE) begin
      rd_byte = charge_percent;
    end else if (acc_addr == `CODE_MAX_ERR) begin
      rd_byte = max_error_percent;
    end else if (in_mfr) begin
      rd_byte = mfr_byte;
    end else if (in_chem) begin
      rd_byte = chem_byte;
    end else begin
      rd_byte = acc_addr[0] ? word[15:8] : word[7:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid_ff <= 1'b0;
    end else if (ce) begin
      rd_valid_ff <= take && !acc_write;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_ff <= `RST_BYTE;
    end else if (take && !acc_write) begin
      rd_data_ff <= rd_byte;
    end
  end

endmodule // gauge_command_decoder

`default_nettype wire

// ---- test/gauge_command_decoder_assertions.sv ----
// assertion checker for the gauge command decoder ports
`timescale 1ns/1ps
`default_nettype none
module gauge_command_decoder_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic        normal_mode,
  input wire logic        acc_valid,
  input wire logic        acc_write,
  input wire logic [7:0]  acc_addr,
  input wire logic [7:0]  acc_wdata,
  input wire logic        rd_valid_ff,
  input wire logic [7:0]  rd_data_ff,
  input wire logic [7:0]  charge_percent,
  input wire logic [15:0] remaining_capacity,
  input wire logic        sealed_ff,
  input wire logic        cal_allow_ff,
  input wire logic        gauging_algorithm_enable_ff,
  input wire logic        deep_sleep_flag_ff,
  input wire logic        board_cal_start_ff,
  input wire logic        full_reset_ff
);
  logic        take;
  logic        rd;
  logic        exec;
  logic [7:0]  lo_ff;
  logic [15:0] sub;
  assign take = ce && acc_valid && normal_mode;
  assign rd   = take && !acc_write;
  assign exec = take && acc_write && acc_addr == 8'h01;
  assign sub  = {acc_wdata, lo_ff};
  // pending low byte of a subcommand
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) lo_ff <= 8'h00;
    else if (take && acc_write && acc_addr == 8'h00) lo_ff <= acc_wdata;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  read_answer_a: assert property (rd |=> rd_valid_ff)
    else $error("read not answered");
  quiet_idle_a: assert property (ce && !rd |=> !rd_valid_ff)
    else $error("answer without accepted read");
  charge_byte_a: assert property (rd && acc_addr == 8'h02
    |=> rd_data_ff == $past(charge_percent)) else $error("wrong charge byte");
  word_high_a: assert property (rd && acc_addr == 8'h05
    |=> rd_data_ff == $past(remaining_capacity[15:8])) else $error("wrong high byte");
  seal_cmd_a: assert property (exec && sub == 16'h0020 |=> sealed_ff)
    else $error("seal not taken");
  seal_hold_a: assert property (sealed_ff |=> sealed_ff)
    else $error("sealed state lost");
  reset_locked_a: assert property (sealed_ff && exec && sub == 16'h0041
    |=> !full_reset_ff) else $error("reset while sealed");
  board_cal_a: assert property (exec && sub == 16'h0009
    |=> board_cal_start_ff ##1 !board_cal_start_ff) else $error("bad board pulse");
  cal_toggle_a: assert property (exec && sub == 16'h002D && !sealed_ff
    |=> cal_allow_ff != $past(cal_allow_ff)) else $error("cal enable not toggled");
  sleep_flag_a: assert property (exec && sub == 16'h0010
    |=> deep_sleep_flag_ff [*3]) else $error("sleep flag not set");
  qen_sticky_a: assert property (gauging_algorithm_enable_ff
    |=> gauging_algorithm_enable_ff) else $error("algorithm enable lost");
endmodule // gauge_command_decoder_checker

bind gauge_command_decoder gauge_command_decoder_checker i_gauge_command_decoder_checker (
  .clk, .rst_n, .ce, .normal_mode, .acc_valid, .acc_write, .acc_addr, .acc_wdata,
  .rd_valid_ff, .rd_data_ff, .charge_percent, .remaining_capacity, .sealed_ff,
  .cal_allow_ff, .gauging_algorithm_enable_ff, .deep_sleep_flag_ff,
  .board_cal_start_ff, .full_reset_ff);
`default_nettype wire

// ---- test/gauge_host_model.sv ----
// host processor model issuing byte accesses
`timescale 1ns/1ps
`default_nettype none
module gauge_host_model (
  input  wire logic       clk,
  input  wire logic       rd_valid_ff,
  input  wire logic [7:0] rd_data_ff,
  output var  logic       acc_valid,
  output var  logic       acc_write,
  output var  logic [7:0] acc_addr,
  output var  logic [7:0] acc_wdata
);
  initial begin
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_addr  = 8'h00;
    acc_wdata = 8'h00;
  end
  // one byte, held until idle or the next byte
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    acc_valid = 1'b1;
    acc_write = w;
    acc_addr  = a;
    acc_wdata = d;
  endtask
  // released lines carry inverted leftovers
  task automatic idle();
    @(negedge clk);
    acc_valid = 1'b0;
    acc_write = ~acc_write;
    acc_addr  = ~acc_addr;
    acc_wdata = ~acc_wdata;
  endtask
  task automatic sub(input logic [15:0] c);
    put(1'b1, 8'h00, c[7:0]);
    put(1'b1, 8'h01, c[15:8]);
    idle();
  endtask
  task automatic get(input logic [7:0] a, output logic [7:0] d, output logic ok);
    put(1'b0, a, 8'h00);
    idle();
    for (int n = 0; n < 4 && rd_valid_ff !== 1'b1; n++) @(negedge clk);
    ok = rd_valid_ff === 1'b1;
    d  = rd_data_ff;
  endtask
  task automatic get16(input logic [7:0] a, output logic [15:0] w, output logic ok);
    logic ok2;
    get(a, w[7:0], ok);
    get(a + 8'h01, w[15:8], ok2);
    ok = ok && ok2;
  endtask
endmodule // gauge_host_model
`default_nettype wire

// ---- test/gauge_command_decoder_tb.sv ----
// self-checking bench for the gauge command decoder
`timescale 1ns/1ps
`default_nettype none
module gauge_command_decoder_tb;
  localparam logic [15:0]  DEV_TYPE = 16'h0B0C; // arbitrary value
  localparam logic [127:0] MFR      = "TEST VENDOR NAME";
  localparam logic [31:0]  CHEM     = "CELL";
  logic        clk, rst_n, ce, normal_mode;
  logic        acc_valid, acc_write, rd_valid_ff;
  logic [7:0]  acc_addr, acc_wdata, rd_data_ff, charge_percent, max_error_percent;
  logic [15:0] meas [8];
  logic [15:0] idv [6];
  logic [6:0]  st;
  logic        sealed_ff, cal_allow_ff, cal_mode_ff, gauging_algorithm_enable_ff;
  logic        vok_ff, deep_sleep_flag_ff, board_cal_start_ff, counter_offset_measure_ff;
  logic        counter_offset_commit_ff, full_reset_ff, gauging_start_ff;
  logic [4:0]  pv;
  int          fails, check_count;
  assign pv = {board_cal_start_ff, counter_offset_measure_ff, counter_offset_commit_ff,
               full_reset_ff, gauging_start_ff};

  gauge_command_decoder #(.DEVICE_TYPE(DEV_TYPE), .MFR_TEXT(MFR), .CHEM_TEXT(CHEM))
    i_gauge_command_decoder (.clk, .rst_n, .ce, .normal_mode, .acc_valid, .acc_write,
    .acc_addr, .acc_wdata, .rd_valid_ff, .rd_data_ff, .charge_percent, .max_error_percent,
    .remaining_capacity(meas[0]), .full_charge_capacity(meas[1]),
    .pack_potential_mv(meas[2]), .mean_current(meas[3]), .thermal_reading(meas[4]),
    .gauge_status_word_a(meas[5]), .instant_current(meas[6]), .gauge_status_word_b(meas[7]),
    .fw_rev(idv[0]), .hw_rev(idv[1]), .chem_code(idv[2]), .cfg_rev(idv[3]),
    .reset_count(idv[4]), .counter_offset_measure(idv[5]), .checksum_valid(st[0]),
    .board_cal_busy(st[1]), .cc_cal_busy(st[2]), .sleep_mode(st[3]),
    .const_power_mode(st[4]), .ra_update_off(st[5]), .vok_clear(st[6]), .sealed_ff,
    .cal_allow_ff, .cal_mode_ff, .gauging_algorithm_enable_ff, .vok_ff, .deep_sleep_flag_ff,
    .board_cal_start_ff, .counter_offset_measure_ff, .counter_offset_commit_ff,
    .full_reset_ff, .gauging_start_ff);

  gauge_host_model i_gauge_host_model (.clk, .rd_valid_ff, .rd_data_ff, .acc_valid,
    .acc_write, .acc_addr, .acc_wdata);

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] w);
    logic ok;
    i_gauge_host_model.get16(a, w, ok);
    if (!ok) begin
      fails++;
      stop_test();
    end
  endtask
  task automatic sc(input logic [15:0] c);
    i_gauge_host_model.sub(c);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_std();
    logic [15:0] w;
    sc(16'h0000);
    rd16(8'h00, w);
    cmp("status at reset", 16'h0A14, w);
    rd16(8'h02, w);
    cmp("charge pair", {max_error_percent, charge_percent}, w);
    for (int i = 0; i < 8; i++) begin
      i_gauge_host_model.put(1'b1, 8'(4 + 2 * i), 8'hFF);
      i_gauge_host_model.idle();
      rd16(8'(4 + 2 * i), w);
      cmp("measurement word", meas[i], w);
    end
    rd16(8'h30, w);
    cmp("unmapped code", 16'h0000, w);
    for (int k = 0; k < 16; k += 2) begin
      rd16(8'(8'h40 + k), w);
      cmp("maker text", {MFR[8*(14-k)+:8], MFR[8*(15-k)+:8]}, w);
    end
    for (int k = 0; k < 4; k += 2) begin
      rd16(8'(8'h50 + k), w);
      cmp("chemistry text", {CHEM[8*(2-k)+:8], CHEM[8*(3-k)+:8]}, w);
    end
  endtask
  task automatic t_query();
    logic [15:0] w;
    logic [7:0]  b;
    logic        ok;
    logic [15:0] cmd [7];
    logic [15:0] exp [7];
    cmd = '{16'h0001, 16'h0002, 16'h0003, 16'h0005, 16'h0008, 16'h000C, 16'h0007};
    exp = '{DEV_TYPE, idv[0], idv[1], idv[4], idv[2], idv[3], 16'h000C};
    for (int i = 0; i < 7; i++) begin
      sc(cmd[i]);
      rd16(8'h00, w);
      cmp("query answer", exp[i], w);
    end
    @(negedge clk);
    normal_mode = 1'b0;
    sc(16'h0010);
    i_gauge_host_model.get(8'h02, b, ok);
    cmp("low power effects", 16'h0000, {14'h0, ok, deep_sleep_flag_ff});
    normal_mode = 1'b1;
    ce = 1'b0;
    sc(16'h0010);
    cmp("frozen effects", 16'h0000, {15'h0, deep_sleep_flag_ff});
    ce = 1'b1;
  endtask
  task automatic t_pulses();
    logic [15:0] w;
    logic [15:0] cmd [5];
    cmd = '{16'h0009, 16'h000A, 16'h000B, 16'h0041, 16'h0021};
    for (int i = 0; i < 5; i++) begin
      sc(cmd[i]);
      cmp("pulse set", 16'(5'b10000 >> i), {11'h0, pv});
      @(negedge clk);
      cmp("pulse end", 16'h0000, {11'h0, pv});
    end
    sc(16'h0010);
    sc(16'h0000);
    rd16(8'h00, w);
    cmp("status flags", 16'h0A37, w);
  endtask
  task automatic t_cal();
    logic [15:0] w;
    sc(16'h002D);
    cmp("cal enable", 16'h0001, {15'h0, cal_allow_ff});
    sc(16'h0081);
    cmp("cal mode", 16'h0001, {15'h0, cal_mode_ff});
    sc(16'h0082);
    rd16(8'h00, w);
    cmp("offset report", idv[5], w);
    sc(16'h0080);
    sc(16'h002D);
    cmp("cal off", 16'h0000, {14'h0, cal_mode_ff, cal_allow_ff});
  endtask
  task automatic t_seal();
    logic [15:0] w;
    sc(16'h0020);
    sc(16'h0000);
    cmp("sealed", 16'h0001, {15'h0, sealed_ff});
    sc(16'h002D);
    sc(16'h0041);
    cmp("refused effects", 16'h0000, {10'h0, pv, cal_allow_ff});
    sc(16'h0033);
    rd16(8'h00, w);
    cmp("sealed status", 16'h2A37, w);
    sc(16'h0009);
    cmp("sealed board cal", 16'h0010, {11'h0, pv});
    sc(16'h0007);
    rd16(8'h00, w);
    cmp("previous code", 16'h0009, w);
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    normal_mode = 1'b1;
    charge_percent = 8'h57;
    max_error_percent = 8'h03;
    st = 7'b0101101;
    for (int i = 0; i < 8; i++) meas[i] = 16'(16'h1357 * (i + 1));
    for (int i = 0; i < 6; i++) idv[i] = 16'(16'h2468 + 16'h0111 * i);
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    t_std();
    t_query();
    t_pulses();
    t_cal();
    t_seal();
    stop_test();
  end
endmodule // gauge_command_decoder_tb
`default_nettype wire
